// ===== common/svc_pkg.sv
// constants and types shared by the supervisor call dispatch block
package svc_pkg;

    // register map, byte addressed; control registers one word apart, trim registers one byte apart
    localparam logic [7:0] ADDR_BANDGAP_TRIM = 8'hea;
    localparam logic [7:0] ADDR_MAIN_OSC_TRIM = 8'he8;
    localparam logic [7:0] ADDR_LOW_OSC_TRIM = 8'he9;
    localparam logic [7:0] ADDR_SVC_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SVC_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CPU_REGS = 8'h08;
    localparam logic [7:0] ADDR_CPU_PTRS = 8'h0c;
    localparam logic [7:0] ADDR_MBOX_LO = 8'h10;
    localparam logic [7:0] ADDR_MBOX_HI = 8'h14;
    localparam logic [7:0] ADDR_FLASH_WIN = 8'h18;
    localparam logic [7:0] ADDR_SRAM_WIN = 8'h1c;

    localparam logic [7:0] MBOX_BASE = 8'hf8;
    localparam int MBOX_BYTES = 8;
    localparam logic [7:0] CALL_KEY = 8'h3a;
    localparam logic [7:0] SP_CALL_OFFSET = 8'h03;
    localparam int BLOCK_BYTES = 64;
    localparam int FLASH_BLOCKS = 256;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    localparam int FLAG_SUPV_BIT = 3;
    localparam int BG_OFFSET_LSB = 0;
    localparam int BG_OFFSET_W = 4;

    localparam logic [7:0] SEL_SILICON_ID = 8'h00;
    localparam logic [7:0] SEL_TRIMS = 8'h01;

    // service function codes carried in the accumulator
    typedef enum logic [7:0] {
        FN_RESET = 8'h00,
        FN_READ_BLOCK = 8'h01,
        FN_WRITE_BLOCK = 8'h02,
        FN_ERASE_BLOCK = 8'h03,
        FN_PROTECT_BLOCK = 8'h04,
        FN_ERASE_ALL = 8'h05,
        FN_TABLE_READ = 8'h06,
        FN_CHECKSUM = 8'h07,
        FN_CALIBRATE = 8'h08
    } func_e;

    // cpu state visible to the supervisor
    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] acc;
        logic [7:0] x;
        logic [7:0] sp;
        logic [15:0] pc;
    } cpu_state_s;

    // factory trim set, all values are parameters at top level
    typedef struct packed {
        logic [7:0] bg_5v0;
        logic [7:0] osc_5v0;
        logic [7:0] bg_3v3;
        logic [7:0] osc_3v3;
        logic [7:0] low_osc;
    } trim_set_s;

endpackage

// ===== logic/svc_checksum.sv
// running 16-bit sum over flash bytes for the checksum service
`timescale 1ns/1ps
module svc_checksum
    import svc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic add_en,
    input wire logic [7:0] data_in,
    output logic [15:0] sum_q
);

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sum_q <= 16'h0000;
        end else if (clk_en) begin
            if (clear) begin
                sum_q <= 16'h0000;
            end else if (add_en) begin
                sum_q <= sum_q + {8'h00, data_in};
            end
        end
    end

endmodule

// ===== logic/supervisor_call_dispatch.sv
// supervisor call dispatcher with flash, sram mailbox and trim registers
`timescale 1ns/1ps
module supervisor_call_dispatch
    import svc_pkg::*;
#(
    parameter logic [7:0] TRIM_BG_5V0 = 8'h48,
    parameter logic [7:0] TRIM_OSC_5V0 = 8'h80,
    parameter logic [7:0] TRIM_BG_3V3 = 8'h44,
    parameter logic [7:0] TRIM_OSC_3V3 = 8'h7c,
    parameter logic [7:0] TRIM_LOW_OSC = 8'h10,
    // identity values below are arbitrary
    parameter logic [7:0] SILICON_ID1 = 8'h5a,
    parameter logic [7:0] SILICON_ID0 = 8'h01,
    parameter logic [7:0] REVISION_A = 8'h41,
    parameter logic [7:0] REVISION_X = 8'h00
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [7:0] bandgap_trim,
    output logic [7:0] main_oscillator_trim,
    output logic [7:0] low_speed_oscillator_trim,
    output logic svc_busy
);

    ////////////////////////////////////////////////////////////////////
    // storage
    localparam int FLASH_BYTES = FLASH_BLOCKS * BLOCK_BYTES;

    logic [7:0] sram_q [0:255];
    logic [7:0] flash_q [0:FLASH_BYTES-1];
    logic [1:0] protect_q [0:FLASH_BLOCKS-1];

    typedef enum logic [3:0] {
        ST_IDLE, ST_PUSH_FLAGS, ST_PUSH_PCL, ST_PUSH_PCH, ST_DISPATCH,
        ST_COPY, ST_SUM, ST_TABLE, ST_RET_PCH, ST_RET_PCL, ST_RET_FLAGS
    } state_e;

    state_e state_q;
    cpu_state_s cpu_q;
    logic [15:0] ret_pc_q;
    logic [7:0] func_q;
    logic [6:0] idx_q;
    logic [13:0] fptr_q;
    logic [7:0] sptr_q;
    logic [7:0] blocks_left_q;
    logic [2:0] op_q;
    logic [7:0] fail_q;
    logic [15:0] sum_w;
    logic sum_clear;
    logic sum_add;

    localparam logic [2:0] OP_READ = 3'd0;
    localparam logic [2:0] OP_WRITE = 3'd1;
    localparam logic [2:0] OP_ERASE = 3'd2;
    localparam logic [2:0] OP_ALL = 3'd3;
    localparam logic [1:0] PROT_DEFAULT = 2'b10;

    // accepting a bus request: avoid clobbering state mid-service
    logic bus_req;
    logic bus_ok;
    logic rd_take;
    logic rd_done_q;
    assign bus_req = avs_read | avs_write;
    // read data stands at the accepting edge
    assign rd_take = clk_en & avs_read & (state_q == ST_IDLE) & ~rd_done_q;
    assign bus_ok = bus_req & (state_q == ST_IDLE) & clk_en
        & (avs_write | rd_done_q);
    assign avs_waitrequest = ~bus_ok;
    assign svc_busy = (state_q != ST_IDLE);

    function automatic logic [7:0] mbox(input logic [2:0] i);
        return sram_q[MBOX_BASE + {5'b0, i}];
    endfunction

    function automatic logic key_ok(input logic [7:0] sp);
        // caller writes the stack pointer as it stands after the pushes
        return mbox(3'd0) == CALL_KEY && mbox(3'd1) == sp;
    endfunction

    logic wr_ctrl;
    assign wr_ctrl = bus_ok & avs_write & (avs_address == ADDR_SVC_CTRL)
        & avs_byteenable[0] & avs_writedata[0];

    svc_checksum u_sum (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .clear(sum_clear),
        .add_en(sum_add),
        .data_in(flash_q[fptr_q]),
        .sum_q(sum_w)
    );

    assign sum_clear = (state_q == ST_DISPATCH);
    assign sum_add = (state_q == ST_SUM);

    ////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else if (clk_en) begin
            unique case (state_q)
                ST_IDLE: if (wr_ctrl) state_q <= ST_PUSH_FLAGS;
                ST_PUSH_FLAGS: state_q <= ST_PUSH_PCL;
                ST_PUSH_PCL: state_q <= ST_PUSH_PCH;
                ST_PUSH_PCH: state_q <= ST_DISPATCH;
                ST_DISPATCH: begin
                    if (func_q == FN_RESET) begin
                        state_q <= ST_IDLE;
                    end else if (!key_ok(cpu_q.sp)) begin
                        state_q <= ST_RET_PCH;
                    end else begin
                        unique case (func_e'(func_q))
                            FN_READ_BLOCK, FN_WRITE_BLOCK, FN_ERASE_BLOCK,
                            FN_ERASE_ALL: state_q <= ST_COPY;
                            FN_CHECKSUM: state_q <= (mbox(3'd2) == 8'h00)
                                ? ST_RET_PCH : ST_SUM;
                            FN_TABLE_READ: state_q <= ST_TABLE;
                            default: state_q <= ST_RET_PCH;
                        endcase
                    end
                end
                ST_COPY: if (idx_q == 7'(BLOCK_BYTES - 1)
                    && (op_q != OP_ALL || fptr_q == 14'(FLASH_BYTES - 1)))
                    state_q <= ST_RET_PCH;
                ST_SUM: if (idx_q == 7'(BLOCK_BYTES - 1)
                    && blocks_left_q == 8'd1) state_q <= ST_RET_PCH;
                ST_TABLE: state_q <= ST_RET_PCH;
                ST_RET_PCH: state_q <= ST_RET_PCL;
                ST_RET_PCL: state_q <= ST_RET_FLAGS;
                ST_RET_FLAGS: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cpu view: flags, pc, sp, a, x and trap entry
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_q <= '0;
            ret_pc_q <= 16'h0000;
            func_q <= 8'h00;
        end else if (clk_en) begin
            if (bus_ok && avs_write && avs_address == ADDR_CPU_REGS) begin
                if (avs_byteenable[0]) cpu_q.flags <= avs_writedata[7:0];
                if (avs_byteenable[1]) cpu_q.acc <= avs_writedata[15:8];
                if (avs_byteenable[2]) cpu_q.x <= avs_writedata[23:16];
            end
            if (bus_ok && avs_write && avs_address == ADDR_CPU_PTRS) begin
                if (avs_byteenable[0]) cpu_q.sp <= avs_writedata[7:0];
                if (avs_byteenable[2]) cpu_q.pc[7:0] <= avs_writedata[23:16];
                if (avs_byteenable[3]) cpu_q.pc[15:8] <= avs_writedata[31:24];
            end
            unique case (state_q)
                ST_IDLE: if (wr_ctrl) begin
                    func_q <= cpu_q.acc;
                    ret_pc_q <= cpu_q.pc;
                end
                ST_PUSH_FLAGS: begin
                    cpu_q.flags[FLAG_SUPV_BIT] <= 1'b1;
                    cpu_q.pc <= 16'h0000;
                    cpu_q.sp <= cpu_q.sp + 8'd1;
                end
                ST_PUSH_PCL, ST_PUSH_PCH: cpu_q.sp <= cpu_q.sp + 8'd1;
                ST_DISPATCH: if (func_q == FN_RESET) begin
                    cpu_q.pc <= 16'h0000;
                    cpu_q.sp <= 8'h00;
                    cpu_q.flags <= 8'h00;
                end
                ST_TABLE: if (mbox(3'd2) == SEL_SILICON_ID) begin
                    cpu_q.acc <= REVISION_A;
                    cpu_q.x <= REVISION_X;
                end else begin
                    cpu_q.acc <= REVISION_A;
                    cpu_q.x <= mbox(3'd2);
                end
                ST_RET_PCH: begin
                    cpu_q.pc[15:8] <= sram_q[cpu_q.sp - 8'd1];
                    cpu_q.sp <= cpu_q.sp - 8'd1;
                end
                ST_RET_PCL: begin
                    cpu_q.pc[7:0] <= sram_q[cpu_q.sp - 8'd1];
                    cpu_q.sp <= cpu_q.sp - 8'd1;
                end
                ST_RET_FLAGS: begin
                    cpu_q.flags <= sram_q[cpu_q.sp - 8'd1]
                        & ~(8'h01 << FLAG_SUPV_BIT);
                    cpu_q.sp <= cpu_q.sp - 8'd1;
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // block transfer pointers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            idx_q <= 7'd0;
            fptr_q <= 14'd0;
            sptr_q <= 8'h00;
            op_q <= OP_READ;
            blocks_left_q <= 8'h00;
            fail_q <= 8'h00;
        end else if (clk_en) begin
            unique case (state_q)
                ST_DISPATCH: begin
                    idx_q <= 7'd0;
                    sptr_q <= mbox(3'd3);
                    blocks_left_q <= mbox(3'd2);
                    fptr_q <= (func_q == FN_CHECKSUM
                        || func_q == FN_ERASE_ALL)
                        ? 14'd0 : {mbox(3'd2), 6'd0};
                    unique case (func_e'(func_q))
                        FN_WRITE_BLOCK: op_q <= OP_WRITE;
                        FN_ERASE_BLOCK: op_q <= OP_ERASE;
                        FN_ERASE_ALL: op_q <= OP_ALL;
                        default: op_q <= OP_READ;
                    endcase
                    if (func_q != FN_RESET && !key_ok(cpu_q.sp))
                        fail_q <= fail_q + 8'd1;
                end
                ST_COPY, ST_SUM: begin
                    idx_q <= (idx_q == 7'(BLOCK_BYTES - 1)) ? 7'd0
                        : idx_q + 7'd1;
                    fptr_q <= fptr_q + 14'd1;
                    sptr_q <= sptr_q + 8'd1;
                    if (state_q == ST_SUM && idx_q == 7'(BLOCK_BYTES - 1))
                        blocks_left_q <= blocks_left_q - 8'd1;
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flash array and protection bits
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (state_q == ST_COPY && op_q != OP_READ
                && protect_q[fptr_q[13:6]] != 2'b11)
                flash_q[fptr_q] <= (op_q == OP_WRITE) ? sram_q[sptr_q]
                    : ERASED_BYTE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int b = 0; b < FLASH_BLOCKS; b++)
                protect_q[b] <= PROT_DEFAULT;
        end else if (clk_en && state_q == ST_DISPATCH
            && func_q == FN_PROTECT_BLOCK && key_ok(cpu_q.sp)) begin
            protect_q[mbox(3'd2)] <= 2'(mbox(3'd3));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sram: stack pushes, block read copy and mailbox results
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            if (bus_ok && avs_write && avs_address == ADDR_SRAM_WIN
                && avs_byteenable[0])
                sram_q[avs_writedata[15:8]] <= avs_writedata[7:0];
            unique case (state_q)
                ST_PUSH_FLAGS: sram_q[cpu_q.sp] <= cpu_q.flags;
                ST_PUSH_PCL: sram_q[cpu_q.sp] <= ret_pc_q[7:0];
                ST_PUSH_PCH: sram_q[cpu_q.sp] <= ret_pc_q[15:8];
                ST_COPY: if (op_q == OP_READ)
                    sram_q[sptr_q] <= flash_q[fptr_q];
                ST_TABLE: begin
                    for (int i = 0; i < MBOX_BYTES; i++)
                        sram_q[MBOX_BASE + 8'(i)] <= 8'h00;
                    if (mbox(3'd2) == SEL_SILICON_ID) begin
                        sram_q[MBOX_BASE] <= SILICON_ID1;
                        sram_q[MBOX_BASE + 8'd1] <= SILICON_ID0;
                    end else if (mbox(3'd2) == SEL_TRIMS) begin
                        sram_q[MBOX_BASE] <= TRIM_BG_3V3;
                        sram_q[MBOX_BASE + 8'd1] <= TRIM_OSC_3V3;
                        sram_q[MBOX_BASE + 8'd4] <= TRIM_BG_5V0;
                        sram_q[MBOX_BASE + 8'd5] <= TRIM_OSC_5V0;
                    end
                end
                ST_RET_PCH: if (func_q != FN_TABLE_READ) begin
                    sram_q[MBOX_BASE] <= (func_q == FN_CHECKSUM)
                        ? sum_w[15:8] : 8'h00;
                    sram_q[MBOX_BASE + 8'd1] <= (func_q == FN_CHECKSUM)
                        ? sum_w[7:0] : 8'h00;
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // trim registers
    logic cal_now;
    assign cal_now = state_q == ST_DISPATCH && (func_q == FN_RESET
        || (func_q == FN_CALIBRATE && key_ok(cpu_q.sp)));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bandgap_trim <= TRIM_BG_5V0;
            main_oscillator_trim <= TRIM_OSC_5V0;
            low_speed_oscillator_trim <= TRIM_LOW_OSC;
        end else if (clk_en) begin
            if (cal_now) begin
                bandgap_trim <= TRIM_BG_5V0;
                main_oscillator_trim <= TRIM_OSC_5V0;
                low_speed_oscillator_trim <= TRIM_LOW_OSC;
            end else if (bus_ok && avs_write && avs_byteenable[0]) begin
                // bits [3:0] steer offset trim of the reference
                if (avs_address == ADDR_BANDGAP_TRIM)
                    bandgap_trim <= avs_writedata[7:0];
                if (avs_address == ADDR_MAIN_OSC_TRIM)
                    main_oscillator_trim <= avs_writedata[7:0];
                if (avs_address == ADDR_LOW_OSC_TRIM)
                    low_speed_oscillator_trim <= avs_writedata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_done_q <= 1'b0;
        end else if (clk_en) begin
            rd_done_q <= rd_take;
        end
    end

    // bus read data; trims are write-only and read zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_take) begin
            unique case (avs_address)
                ADDR_SVC_STATUS: avs_readdata <= {16'h0000, fail_q,
                    7'h00, svc_busy};
                ADDR_CPU_REGS: avs_readdata <= {8'h00, cpu_q.x,
                    cpu_q.acc, cpu_q.flags};
                ADDR_CPU_PTRS: avs_readdata <= {cpu_q.pc, 8'h00, cpu_q.sp};
                ADDR_MBOX_LO: avs_readdata <= {mbox(3'd3), mbox(3'd2),
                    mbox(3'd1), mbox(3'd0)};
                ADDR_MBOX_HI: avs_readdata <= {mbox(3'd7), mbox(3'd6),
                    mbox(3'd5), mbox(3'd4)};
                ADDR_SRAM_WIN: avs_readdata <= {24'h0,
                    sram_q[avs_writedata[15:8]]};
                ADDR_FLASH_WIN: avs_readdata <= {24'h0,
                    flash_q[avs_writedata[13:0]]};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule

// ===== dv/cpu_caller_model.sv
// firmware side model issuing avalon register calls
`timescale 1ns/1ps
module cpu_caller_model (
    input wire logic core_clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    output logic stuck
);
    initial begin
        {avs_read, avs_write, stuck} = 3'b000;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
    end

    // firmware never issues protect block or erase all
    // released address and data lines show inverted values, never the last ones
    task automatic access(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 500);
        stuck = (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
        @(negedge core_clk);
    endtask
endmodule

// ===== dv/svc_dispatch_checker.sv
// assertions on the supervisor call dispatch ports
`timescale 1ns/1ps
module svc_dispatch_checker
    import svc_pkg::*;
#(
    parameter logic [7:0] TRIM_BG_5V0 = 8'h48,
    parameter logic [7:0] TRIM_OSC_5V0 = 8'h80,
    parameter logic [7:0] TRIM_LOW_OSC = 8'h10
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [7:0] bandgap_trim,
    input wire logic [7:0] main_oscillator_trim,
    input wire logic [7:0] low_speed_oscillator_trim,
    input wire logic svc_busy
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    logic rd_ok;
    logic wr_ok;
    assign rd_ok = avs_read && !avs_waitrequest;
    assign wr_ok = avs_write && !avs_waitrequest;
    ////////////////////////////////////////////////////////////////////////
    property p_reset_trims;
        $rose(rst_b) |-> !svc_busy && bandgap_trim == TRIM_BG_5V0 &&
            main_oscillator_trim == TRIM_OSC_5V0 &&
            low_speed_oscillator_trim == TRIM_LOW_OSC;
    endproperty
    a_reset_trims: assert property (p_reset_trims) else $error("trims");
    property p_trim_write;
        wr_ok && avs_address == ADDR_BANDGAP_TRIM && avs_byteenable[0]
            |=> bandgap_trim == $past(avs_writedata[7:0]);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim set");
    property p_wo_read;
        rd_ok && avs_address == ADDR_BANDGAP_TRIM |-> avs_readdata == 32'h0;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("trim readback");
    property p_trap_busy;
        wr_ok && avs_address == ADDR_SVC_CTRL && avs_writedata[0] |=> svc_busy;
    endproperty
    a_trap_busy: assert property (p_trap_busy) else $error("no trap");
    property p_stall;
        svc_busy |-> avs_waitrequest;
    endproperty
    a_stall: assert property (p_stall) else $error("bus in service");
    // every service must come back, block copies included
    property p_bound;
        $rose(svc_busy) |-> ##[1:300] !svc_busy;
    endproperty
    a_bound: assert property (p_bound) else $error("service never ends");
    property p_hold;
        !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_freeze;
        !clk_en |-> avs_waitrequest;
    endproperty
    a_freeze: assert property (p_freeze) else $error("bus taken frozen");
endmodule

bind supervisor_call_dispatch svc_dispatch_checker #(
    .TRIM_BG_5V0(TRIM_BG_5V0), .TRIM_OSC_5V0(TRIM_OSC_5V0),
    .TRIM_LOW_OSC(TRIM_LOW_OSC)
) i_chk (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bandgap_trim(bandgap_trim), .main_oscillator_trim(main_oscillator_trim),
    .low_speed_oscillator_trim(low_speed_oscillator_trim),
    .svc_busy(svc_busy)
);

// ===== dv/supervisor_call_dispatch_test.sv
// self-checking bench for the supervisor call dispatch block
`timescale 1ns/1ps
module supervisor_call_dispatch_test
    import svc_pkg::*;
;
    // trim and identity values are arbitrary
    localparam logic [7:0] BG5 = 8'h4b, OSC5 = 8'h83, BG3 = 8'h45;
    localparam logic [7:0] OSC3 = 8'h7d, LOW = 8'h12, ID1 = 8'h6c;
    localparam logic [7:0] ID0 = 8'h02, REVA = 8'h32, REVX = 8'h07;
    localparam logic [31:0] DEF = {8'h0, BG5, OSC5, LOW};
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic avs_read, avs_write, avs_waitrequest, svc_busy, stuck;
    logic [7:0] avs_address, bg_trim, osc_trim, low_trim;
    logic [31:0] avs_writedata, avs_readdata, q, trims;
    logic [3:0] avs_byteenable;
    int failures = 0;
    int checks = 0;
    assign trims = {8'h0, bg_trim, osc_trim, low_trim};
    always #10 core_clk = ~core_clk;

    supervisor_call_dispatch #(
        .TRIM_BG_5V0(BG5), .TRIM_OSC_5V0(OSC5), .TRIM_BG_3V3(BG3),
        .TRIM_OSC_3V3(OSC3), .TRIM_LOW_OSC(LOW), .SILICON_ID1(ID1),
        .SILICON_ID0(ID0), .REVISION_A(REVA), .REVISION_X(REVX)
    ) i_dut (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bandgap_trim(bg_trim),
        .main_oscillator_trim(osc_trim),
        .low_speed_oscillator_trim(low_trim), .svc_busy(svc_busy)
    );
    cpu_caller_model i_cpu (
        .core_clk(core_clk), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .stuck(stuck)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (stuck) failures++;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_cpu.access(1'b1, a, d, q);
        if (stuck) results();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        i_cpu.access(1'b0, a, d, q);
        if (stuck) results();
    endtask

    // library call: stack at 20h, flag bit 3 preset so return must clear it
    task automatic svc(input logic [7:0] fn, fa, fb, key);
        logic [63:0] m;
        m = {24'h0, 8'h05, fb, fa, 8'h23, key};
        wr(ADDR_CPU_PTRS, 32'h0100_0020);
        for (int i = 0; i < MBOX_BYTES; i++)
            wr(ADDR_SRAM_WIN, {16'h0, MBOX_BASE + 8'(i), m[8*i +: 8]});
        wr(ADDR_CPU_REGS, {16'h0, fn, 8'h08});
        wr(ADDR_SVC_CTRL, 32'h1);
        rd(ADDR_SVC_STATUS, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        cmp("reset trims", DEF, trims);
        wr(ADDR_BANDGAP_TRIM, 32'h0000_00c7);
        wr(ADDR_MAIN_OSC_TRIM, 32'h0000_0011);
        wr(ADDR_LOW_OSC_TRIM, 32'h0000_0022);
        cmp("trim write", 32'h00c7_1122, trims);
        rd(ADDR_BANDGAP_TRIM, 32'h0);
        cmp("trim read", 32'h0, q);
        rd(8'hf0, 32'h0);
        cmp("unmapped read", 32'h0, q);
        $display("test trims ended");
        svc(FN_CALIBRATE, 8'h00, 8'h00, CALL_KEY);
        cmp("calibrated trims", DEF, trims);
        rd(ADDR_CPU_REGS, 32'h0);
        cmp("flags", 32'h0, {24'h0, q[7:0]});
        rd(ADDR_CPU_PTRS, 32'h0);
        cmp("stack", 32'h20, {24'h0, q[7:0]});
        $display("test calibrate ended");
        for (int s = 0; s < 2; s++) begin
            svc(FN_TABLE_READ, 8'(s), 8'h00, CALL_KEY);
            rd(ADDR_MBOX_LO, 32'h0);
            cmp("table low", s ? {16'h0, OSC3, BG3} :
                {16'h0, ID0, ID1}, q);
            rd(ADDR_MBOX_HI, 32'h0);
            cmp("table high", s ? {16'h0, OSC5, BG5} : 32'h0, q);
            rd(ADDR_CPU_REGS, 32'h0);
            cmp("revision", {16'h0, s ? 8'h01 : REVX, REVA},
                {16'h0, q[23:8]});
        end
        $display("test table read ended");
        svc(FN_ERASE_BLOCK, 8'h00, 8'h00, CALL_KEY);
        svc(FN_CHECKSUM, 8'h01, 8'h00, CALL_KEY);
        rd(ADDR_MBOX_LO, 32'h0);
        cmp("checksum", 32'hc03f, {16'h0, q[15:0]});
        svc(FN_CHECKSUM, 8'h01, 8'h00, 8'h00);
        rd(ADDR_SVC_STATUS, 32'h0);
        cmp("key refusals", 32'h0100, {16'h0, q[15:8], 7'h0, q[0]});
        for (int i = 0; i < BLOCK_BYTES; i++) begin
            wr(ADDR_SRAM_WIN, {16'h0, 8'(8'h40 + i), 8'(i) ^ 8'h5a});
        end
        svc(FN_ERASE_BLOCK, 8'h03, 8'h00, CALL_KEY);
        svc(FN_WRITE_BLOCK, 8'h03, 8'h40, CALL_KEY);
        svc(FN_READ_BLOCK, 8'h03, 8'h80, CALL_KEY);
        for (int i = 0; i < BLOCK_BYTES; i++) begin
            rd(ADDR_FLASH_WIN, 32'(3 * BLOCK_BYTES + i));
            cmp("flash byte", 32'(i ^ 8'h5a), {24'h0, q[7:0]});
            rd(ADDR_SRAM_WIN, {16'h0, 8'(8'h80 + i), 8'h00});
            cmp("sram byte", 32'(i ^ 8'h5a), {24'h0, q[7:0]});
        end
        $display("test flash blocks ended");
        @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        clk_en <= 1'b1;
        wr(ADDR_BANDGAP_TRIM, 32'h0000_00c7);
        svc(FN_RESET, 8'h00, 8'h00, 8'h00);
        cmp("reset service trims", DEF, trims);
        rd(ADDR_CPU_PTRS, 32'h0);
        cmp("pc and sp", 32'h0, {q[31:16], 8'h0, q[7:0]});
        wr(ADDR_BANDGAP_TRIM, 32'h0000_00c7);
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        cmp("trims after reset", DEF, trims);
        $display("test resets ended");
        results();
    end
endmodule
